/* core/sysctl_defines.svh */
// How it works
// - Rise config bit 8 enables RTC alarm wake
// - Config bits 7:0 pick edge wake lines
// - Selected trigger event sets matching pending bit
// - Bus clock equals system clock over divider+1
// - APB reset bits hold peripherals in reset
// - AHB reset bits hold peripherals in reset
// - APB clock enable bits gate peripheral clocks
// - AHB clock enable bits gate peripheral clocks
// - Freeze bits stop clocks during debug halt
// - Identity register reads fixed word, ignores writes
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_WAKE_RISE 12'h020
`define OFS_WAKE_FALL 12'h024
`define OFS_WAKE_PEND 12'h028
`define OFS_WAKE_MASK 12'h02C
`define OFS_BUS_DIV 12'h038
`define OFS_APB_RST 12'h040
`define OFS_AHB_RST 12'h050
`define OFS_APB_CLK 12'h060
`define OFS_AHB_CLK 12'h070
`define OFS_APB_FRZ 12'h080
`define OFS_CHIP_ID 12'h100

// ----------------------------------------------------------------
// Field widths and positions
// ----------------------------------------------------------------
`define EXT_LINES 8
`define WAKE_BITS 9
`define ALARM_BIT 8
`define DIV_BITS 4
`define APB_BITS 29
`define AHB_BITS 4

// ----------------------------------------------------------------
// Reset values and fixed words
// ----------------------------------------------------------------
`define RST_WAKE 9'h000
`define RST_DIV 4'h0
`define RST_APB 29'h0000000
`define RST_AHB 4'h0
// Watchdog, timers, general timers, CAN may freeze
`define FREEZE_MASK 29'h041FC002
// Arbitrary identity value, not tied to any real part
`define CHIP_ID_WORD 32'h5A5A0001

`endif

/* core/sysctl_pkg.sv */
package sysctl_pkg;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  // Classic Wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Peripheral reset and clock gate outputs
  typedef struct packed {
    logic [28:0] apb_rst;
    logic [3:0] ahb_rst;
    logic [28:0] apb_clk_en;
    logic [3:0] ahb_clk_en;
  } periph_ctrl_t;

endpackage

/* core/bus_clock_divider.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defines.svh"

module bus_clock_divider (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Divide factor, ratio is factor plus one
  input wire logic [3:0] bus_divide_factor_i,
  // One-cycle enable for the peripheral bus
  output logic tick_o
);

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // ----------------------------------------------------------------
  // Divider counter
  // ----------------------------------------------------------------
  // Compare with >= so a shrinking factor never strands the count
  always_comb
  begin
    if (cnt_reg >= bus_divide_factor_i)
    begin
      cnt_next = 4'h0;
      tick_next = 1'b1;
    end
    else
    begin
      cnt_next = cnt_reg + 4'h1;
      tick_next = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= `RST_DIV;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule // bus_clock_divider
`default_nettype wire

/* core/sysctl_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defines.svh"

module sysctl_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire sysctl_pkg::wb_req_t wb_i,
  output var sysctl_pkg::wb_rsp_t wb_o,
  // Wake sources from pins and the RTC domain
  input wire logic [7:0] external_wake_lines_i,
  input wire logic rtc_alarm_i,
  // Core debug halt, same clock
  input wire logic debug_halt_i,
  // Peripheral controls
  output var sysctl_pkg::periph_ctrl_t periph_o,
  output logic pbus_tick_o,
  // Wake request and interrupt
  output logic wake_req_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Byte-lane merge for writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Expand byte selects to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return lane_merge(32'h00000000, 32'hFFFFFFFF, sel);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers and edge history
  // ----------------------------------------------------------------
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  logic [8:0] hist_reg;
  logic [8:0] rise_edge;
  logic [8:0] fall_edge;

  // Pins and RTC alarm are asynchronous, two flops before use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 9'h000;
      sync2_reg <= 9'h000;
      hist_reg <= 9'h000;
    end
    else
    begin
      sync1_reg <= {rtc_alarm_i, external_wake_lines_i};
      sync2_reg <= sync1_reg;
      hist_reg <= sync2_reg;
    end
  end

  // Edge detection on the second stage only
  assign rise_edge = sync2_reg & ~hist_reg;
  assign fall_edge = ~sync2_reg & hist_reg;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic req;
  logic wr_fire;
  logic [11:0] ofs;
  logic [31:0] wmask;
  logic [31:0] read_word;

  assign req = wb_i.cyc & wb_i.stb;
  // Writes land on the edge where the master sees ack
  assign wr_fire = req & wb_i.we & ack_reg;
  assign ofs = {wb_i.adr[11:2], 2'b00};
  assign wmask = lane_mask(wb_i.sel);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] rise_cfg_reg;
  logic [7:0] rise_cfg_next;
  logic alarm_en_reg;
  logic alarm_en_next;
  logic [7:0] fall_cfg_reg;
  logic [7:0] fall_cfg_next;
  logic [8:0] pend_reg;
  logic [8:0] pend_next;
  logic [8:0] mask_reg;
  logic [8:0] mask_next;
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic [28:0] apb_rst_reg;
  logic [28:0] apb_rst_next;
  logic [3:0] ahb_rst_reg;
  logic [3:0] ahb_rst_next;
  logic [28:0] apb_clk_reg;
  logic [28:0] apb_clk_next;
  logic [3:0] ahb_clk_reg;
  logic [3:0] ahb_clk_next;
  logic [28:0] frz_reg;
  logic [28:0] frz_next;
  logic [8:0] wake_set;
  logic [8:0] wake_clr;
  logic [31:0] wr_word;

  // Trigger events that are selected
  always_comb
  begin
    wake_set[7:0] = (rise_edge[7:0] & rise_cfg_reg) | (fall_edge[7:0] & fall_cfg_reg);
    wake_set[`ALARM_BIT] = rise_edge[`ALARM_BIT] & alarm_en_reg;
  end

  // Write decode and next state for all software registers
  always_comb
  begin
    rise_cfg_next = rise_cfg_reg;
    alarm_en_next = alarm_en_reg;
    fall_cfg_next = fall_cfg_reg;
    mask_next = mask_reg;
    div_next = div_reg;
    apb_rst_next = apb_rst_reg;
    ahb_rst_next = ahb_rst_reg;
    apb_clk_next = apb_clk_reg;
    ahb_clk_next = ahb_clk_reg;
    frz_next = frz_reg;
    wake_clr = 9'h000;
    wr_word = 32'h00000000;
    if (wr_fire)
    begin
      case (ofs)
        `OFS_WAKE_RISE:
        begin
          wr_word = lane_merge({23'h000000, alarm_en_reg, rise_cfg_reg}, wb_i.dat, wb_i.sel);
          rise_cfg_next = wr_word[7:0];
          alarm_en_next = wr_word[`ALARM_BIT];
        end
        `OFS_WAKE_FALL:
        begin
          wr_word = lane_merge({24'h000000, fall_cfg_reg}, wb_i.dat, wb_i.sel);
          fall_cfg_next = wr_word[7:0];
        end
        `OFS_WAKE_PEND:
        begin
          wake_clr = wb_i.dat[8:0] & wmask[8:0];
        end
        `OFS_WAKE_MASK:
        begin
          wr_word = lane_merge({23'h000000, mask_reg}, wb_i.dat, wb_i.sel);
          mask_next = wr_word[8:0];
        end
        `OFS_BUS_DIV:
        begin
          wr_word = lane_merge({28'h0000000, div_reg}, wb_i.dat, wb_i.sel);
          div_next = wr_word[3:0];
        end
        `OFS_APB_RST:
        begin
          wr_word = lane_merge({3'h0, apb_rst_reg}, wb_i.dat, wb_i.sel);
          apb_rst_next = wr_word[28:0];
        end
        `OFS_AHB_RST:
        begin
          wr_word = lane_merge({28'h0000000, ahb_rst_reg}, wb_i.dat, wb_i.sel);
          ahb_rst_next = wr_word[3:0];
        end
        `OFS_APB_CLK:
        begin
          wr_word = lane_merge({3'h0, apb_clk_reg}, wb_i.dat, wb_i.sel);
          apb_clk_next = wr_word[28:0];
        end
        `OFS_AHB_CLK:
        begin
          wr_word = lane_merge({28'h0000000, ahb_clk_reg}, wb_i.dat, wb_i.sel);
          ahb_clk_next = wr_word[3:0];
        end
        `OFS_APB_FRZ:
        begin
          // Only peripherals that can freeze keep a bit
          wr_word = lane_merge({3'h0, frz_reg}, wb_i.dat, wb_i.sel);
          frz_next = wr_word[28:0] & `FREEZE_MASK;
        end
        default:
        begin
          // Identity and unmapped words ignore writes
          wr_word = 32'h00000000;
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    pend_next = (pend_reg & ~wake_clr) | wake_set;
  end

  // Register stage for software state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rise_cfg_reg <= 8'h00;
      alarm_en_reg <= 1'b0;
      fall_cfg_reg <= 8'h00;
      pend_reg <= `RST_WAKE;
      mask_reg <= `RST_WAKE;
      div_reg <= `RST_DIV;
      apb_rst_reg <= `RST_APB;
      ahb_rst_reg <= `RST_AHB;
      apb_clk_reg <= `RST_APB;
      ahb_clk_reg <= `RST_AHB;
      frz_reg <= `RST_APB;
    end
    else
    begin
      rise_cfg_reg <= rise_cfg_next;
      alarm_en_reg <= alarm_en_next;
      fall_cfg_reg <= fall_cfg_next;
      pend_reg <= pend_next;
      mask_reg <= mask_next;
      div_reg <= div_next;
      apb_rst_reg <= apb_rst_next;
      ahb_rst_reg <= ahb_rst_next;
      apb_clk_reg <= apb_clk_next;
      ahb_clk_reg <= ahb_clk_next;
      frz_reg <= frz_next;
    end
  end

  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  // Unmapped offsets answer with zero rather than hang the bus
  always_comb
  begin
    case (ofs)
      `OFS_WAKE_RISE: read_word = {23'h000000, alarm_en_reg, rise_cfg_reg};
      `OFS_WAKE_FALL: read_word = {24'h000000, fall_cfg_reg};
      `OFS_WAKE_PEND: read_word = {23'h000000, pend_reg};
      `OFS_WAKE_MASK: read_word = {23'h000000, mask_reg};
      `OFS_BUS_DIV: read_word = {28'h0000000, div_reg};
      `OFS_APB_RST: read_word = {3'h0, apb_rst_reg};
      `OFS_AHB_RST: read_word = {28'h0000000, ahb_rst_reg};
      `OFS_APB_CLK: read_word = {3'h0, apb_clk_reg};
      `OFS_AHB_CLK: read_word = {28'h0000000, ahb_clk_reg};
      `OFS_APB_FRZ: read_word = {3'h0, frz_reg};
      `OFS_CHIP_ID: read_word = `CHIP_ID_WORD;
      default: read_word = 32'h00000000;
    endcase
  end

  // One wait state, ack drops the cycle after it was given
  always_comb
  begin
    ack_next = req & ~ack_reg;
    rdat_next = ack_next ? read_word : 32'h00000000;
  end

  // Register stage for the bus answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  sysctl_pkg::periph_ctrl_t ctrl_reg;
  sysctl_pkg::periph_ctrl_t ctrl_next;
  logic wake_reg;
  logic wake_next;
  logic irq_reg;
  logic irq_next;

  // Gate and freeze terms; one cycle behind the registers
  always_comb
  begin
    ctrl_next.apb_rst = apb_rst_reg;
    ctrl_next.ahb_rst = ahb_rst_reg;
    ctrl_next.apb_clk_en = apb_clk_reg & ~(frz_reg & {29{debug_halt_i}});
    ctrl_next.ahb_clk_en = ahb_clk_reg;
    wake_next = |pend_reg;
    irq_next = |(pend_reg & mask_reg);
  end

  // Register stage for outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= '0;
      wake_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      wake_reg <= wake_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus clock divider
  // ----------------------------------------------------------------
  bus_clock_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus_divide_factor_i(div_reg),
    .tick_o(pbus_tick_o)
  );

  assign wb_o.ack = ack_reg;
  assign wb_o.dat = rdat_reg;
  assign periph_o = ctrl_reg;
  assign wake_req_o = wake_reg;
  assign irq_o = irq_reg;

endmodule // sysctl_bank
`default_nettype wire

/* dv/sysctl_bank_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defines.svh"

module sysctl_bank_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire sysctl_pkg::wb_req_t wb_i,
  input wire sysctl_pkg::wb_rsp_t wb_o,
  // Events and debug
  input wire logic [7:0] external_wake_lines_i,
  input wire logic rtc_alarm_i,
  input wire logic debug_halt_i,
  // Controls
  input wire sysctl_pkg::periph_ctrl_t periph_o,
  input wire logic pbus_tick_o,
  input wire logic wake_req_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ------
  // Tick spacing tracker
  // ------
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic [4:0] gap_reg;
  logic [4:0] gap_next;
  logic chg_reg;
  logic chg_next;
  logic div_wr;
  // Divider write lands at the ack edge
  assign div_wr = wb_i.cyc && wb_i.stb && wb_i.we && wb_o.ack && wb_i.sel[0]
    && ({wb_i.adr[11:2], 2'h0} == `OFS_BUS_DIV);
  // First gap after a change is skipped, the counter keeps its old count across the change
  always_comb
  begin
    div_next = div_wr ? wb_i.dat[3:0] : div_reg;
    chg_next = div_wr ? 1'b1 : (pbus_tick_o ? 1'b0 : chg_reg);
    gap_next = pbus_tick_o ? 5'h00 : gap_reg + 5'h01;
  end
  // Register the tracker
  always_ff @(posedge clk_i)
  begin
    div_reg <= rst_i ? 4'h0 : div_next;
    chg_reg <= rst_i ? 1'b1 : chg_next;
    gap_reg <= rst_i ? 5'h00 : gap_next;
  end

  // ------
  // Properties
  // ------
  chk_ack_next: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_o.ack |=> !wb_o.ack)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!wb_o.ack |-> wb_o.dat == 32'h0)
    else $error("read data outside ack");
  chk_id_word: assert property (wb_i.cyc && wb_i.stb && !wb_i.we && !wb_o.ack
    && {wb_i.adr[11:2], 2'h0} == `OFS_CHIP_ID |=> wb_o.dat == `CHIP_ID_WORD)
    else $error("identity word wrong");
  chk_tick_gap: assert property (pbus_tick_o && !chg_reg |-> gap_reg == {1'b0, div_reg})
    else $error("bus tick spacing wrong");
  chk_freeze_only: assert property ($rose(debug_halt_i) && !wb_i.we |=>
    ((periph_o.apb_clk_en ^ $past(periph_o.apb_clk_en)) & ~`FREEZE_MASK) == 29'h0)
    else $error("non-freezable clock stopped");
  chk_irq_pend: assert property (irq_o |-> wake_req_o)
    else $error("irq without pending flag");
  // A clearing write lands on the ack edge and shows on wake_req_o one edge later
  chk_pend_sticky: assert property (wake_req_o
    && !$past(wb_o.ack && wb_i.we) |=> wake_req_o)
    else $error("pending flag lost without write");
  chk_rst_clear: assert property ($past(rst_i) |-> periph_o == '0 && !wake_req_o && !irq_o)
    else $error("outputs not cleared by reset");
endmodule // sysctl_bank_props
`default_nettype wire

/* dv/system_ctrl_reset_clock_gating_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defines.svh"

module system_ctrl_reset_clock_gating_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  sysctl_pkg::wb_req_t wb_i = '0;
  sysctl_pkg::wb_rsp_t wb_o;
  logic [7:0] ext_i = 8'h00;
  logic alarm_i = 1'b0;
  logic halt_i = 1'b0;
  sysctl_pkg::periph_ctrl_t periph_o;
  logic tick_o;
  logic wake_o;
  logic irq_o;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h000158A4;
  localparam logic [11:0] OFS [6] = '{`OFS_BUS_DIV, `OFS_APB_RST, `OFS_AHB_RST,
    `OFS_APB_CLK, `OFS_AHB_CLK, `OFS_APB_FRZ};
  localparam logic [31:0] MSK [6] = '{32'h0000000F, 32'h1FFFFFFF, 32'h0000000F,
    32'h1FFFFFFF, 32'h0000000F, {3'h0, `FREEZE_MASK}};
  logic [31:0] sh [6] = '{default: 32'h0};

  // 5 ns period
  always #2.5 clk_i = ~clk_i;

  sysctl_bank uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .external_wake_lines_i(ext_i), .rtc_alarm_i(alarm_i), .debug_halt_i(halt_i),
    .periph_o(periph_o), .pbus_tick_o(tick_o), .wake_req_o(wake_o), .irq_o(irq_o));

  // ------
  // Helpers
  // ------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Byte lanes not selected keep the old value
  function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (n & m);
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until ack is sampled, then released for one idle cycle
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] rd);
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: s, adr: {20'h0, a}, dat: d};
    do @(posedge clk_i); while (wb_o.ack !== 1'b1);
    rd = wb_o.dat;
    wb_i <= '0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, a, 32'h0, 4'hF, d);
    check(d, exp);
  endtask
  task automatic wr_reg(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] x;
    wb(1'b1, OFS[i], d, s, x);
    sh[i] = merge(sh[i], d, s) & MSK[i];
  endtask
  task automatic tick_wait();
    do @(posedge clk_i); while (tick_o !== 1'b1);
  endtask

  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end

  // ------
  // Main sequence
  // ------
  initial
  begin
    logic [31:0] d;
    int n;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, identity, unmapped place
    for (int i = 0; i < 6; i++) rd_chk(OFS[i], 32'h0);
    rd_chk(`OFS_CHIP_ID, `CHIP_ID_WORD);
    wb(1'b1, `OFS_CHIP_ID, rnd(), 4'hF, d);
    rd_chk(`OFS_CHIP_ID, `CHIP_ID_WORD);
    wb(1'b1, 12'h200, 32'hFFFFFFFF, 4'hF, d);
    rd_chk(12'h200, 32'h0);
    // Random writes with random byte lanes
    repeat (30)
    begin
      n = int'(rnd() % 6);
      wr_reg(n, rnd(), 4'(rnd()));
      rd_chk(OFS[n], sh[n]);
      check({3'h0, periph_o.apb_rst}, sh[1]);
      check({28'h0, periph_o.ahb_rst}, sh[2]);
      check({3'h0, periph_o.apb_clk_en}, sh[3]);
      check({28'h0, periph_o.ahb_clk_en}, sh[4]);
    end
    // Debug freeze on and off
    wr_reg(3, 32'hFFFFFFFF, 4'hF);
    wr_reg(5, 32'hFFFFFFFF, 4'hF);
    halt_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({3'h0, periph_o.apb_clk_en}, 32'h1FFFFFFF & ~MSK[5]);
    halt_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({3'h0, periph_o.apb_clk_en}, 32'h1FFFFFFF);
    wr_reg(5, 32'h0, 4'hF);
    halt_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({3'h0, periph_o.apb_clk_en}, 32'h1FFFFFFF);
    halt_i <= 1'b0;
    // Divider extremes and a middle value
    foreach (MSK[k])
    begin
      wr_reg(0, (k == 0) ? 32'h0 : ((k == 1) ? 32'h3 : 32'hF), 4'hF);
      tick_wait();
      tick_wait();
      n = 0;
      do begin @(posedge clk_i); n++; end while (tick_o !== 1'b1);
      check(n, sh[0] + 32'h1);
    end
    // Wake triggers: line 0 rising, line 1 falling, alarm; line 2 unselected
    wb(1'b1, `OFS_WAKE_RISE, 32'h00000101, 4'hF, d);
    wb(1'b1, `OFS_WAKE_FALL, 32'h00000002, 4'hF, d);
    wb(1'b1, `OFS_WAKE_MASK, 32'h00000001, 4'hF, d);
    ext_i <= 8'h06;
    repeat (8) @(posedge clk_i);
    rd_chk(`OFS_WAKE_PEND, 32'h0);
    ext_i <= 8'h05;
    repeat (8) @(posedge clk_i);
    rd_chk(`OFS_WAKE_PEND, 32'h00000003);
    check({30'h0, wake_o, irq_o}, 32'h3);
    alarm_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd_chk(`OFS_WAKE_PEND, 32'h00000103);
    wb(1'b1, `OFS_WAKE_PEND, 32'h0, 4'hF, d);
    rd_chk(`OFS_WAKE_PEND, 32'h00000103);
    wb(1'b1, `OFS_WAKE_PEND, 32'h00000001, 4'hF, d);
    rd_chk(`OFS_WAKE_PEND, 32'h00000102);
    check({30'h0, wake_o, irq_o}, 32'h2);
    wb(1'b1, `OFS_WAKE_PEND, 32'h000001FF, 4'hF, d);
    rd_chk(`OFS_WAKE_PEND, 32'h0);
    check({31'h0, wake_o}, 32'h0);
    // Reset again in mid-run
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({3'h0, periph_o.apb_clk_en}, 32'h0);
    rd_chk(OFS[1], 32'h0);
    print_verdict();
  end
endmodule // system_ctrl_reset_clock_gating_tb

bind sysctl_bank sysctl_bank_props props_i (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
  .wb_o(wb_o), .external_wake_lines_i(external_wake_lines_i), .rtc_alarm_i(rtc_alarm_i),
  .debug_halt_i(debug_halt_i), .periph_o(periph_o), .pbus_tick_o(pbus_tick_o),
  .wake_req_o(wake_req_o), .irq_o(irq_o));
`default_nettype wire
